// ==== shared/wwd_pkg.sv ====
// Constants, types and lookups shared by the window watchdog files.
`default_nettype none
package wwd_pkg;
  // Clock and tick timing.
  localparam int CLK_PERIOD_NS = 8;
  localparam int TICK_TIME_NS = 1000;
  localparam int TICK_CYC = (TICK_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TICK_CNT_W = 24;
  // Register offsets.
  localparam logic [7:0] ADDR_CFG = 8'hA0;
  localparam logic [7:0] ADDR_UPPER = 8'hA1;
  localparam logic [7:0] ADDR_LOWER = 8'hA2;
  localparam logic [7:0] ADDR_SERVICE = 8'hA3;
  localparam logic [7:0] ADDR_PIN = 8'hA4;
  // Reset values and the service write value.
  localparam logic [7:0] CFG_RST = 8'h00;
  localparam logic [7:0] LIMIT_RST = 8'h00;
  localparam logic [7:0] PIN_RST = 8'h00;
  localparam logic [7:0] SERVICE_VALUE = 8'h2A;
  // Configuration bit positions.
  localparam int CFG_EN = 7;
  localparam int CFG_RESTART_SD = 6;
  localparam int CFG_SLOW_SD = 5;
  localparam int CFG_FAST_SD = 4;
  localparam int CFG_SCOPE = 3;
  localparam int CFG_LOCK = 2;
  localparam int CFG_SEL_MSB = 1;
  localparam int CFG_SEL_LSB = 0;
  // Limit register layout; bit 7 is reserved and reads zero.
  localparam int LIM_CNT_MSB = 3;
  localparam int LIM_CNT_LSB = 0;
  localparam int LIM_TB_MSB = 6;
  localparam int LIM_TB_LSB = 4;
  localparam logic [7:0] LIM_MASK = 8'h7F;
  // Service source selections.
  localparam logic [1:0] SEL_PIN_FALL = 2'h0;
  localparam logic [1:0] SEL_PIN_RISE = 2'h1;
  localparam logic [1:0] SEL_PIN_RISE_ALT = 2'h2;
  localparam logic [1:0] SEL_REG_ONLY = 2'h3;
  // Pin configuration register.
  localparam int PIN_MODE_MSB = 2;
  localparam int PIN_MODE_LSB = 0;
  localparam int PIN_LEVEL_BIT = 4;
  localparam int PIN_READ_BIT = 7;
  localparam logic [2:0] PIN_MODE_INIT = 3'h0;
  localparam logic [2:0] PIN_MODE_FAULT = 3'h1;
  localparam logic [2:0] PIN_MODE_INPUT = 3'h4;
  localparam logic [2:0] PIN_MODE_LEVEL = 3'h6;
  // Elapsed time is counted in ticks; widest window is 2 x 15 x 10000.
  localparam int UNIT_W = 20;
  localparam int MULT_W = 14;

  typedef enum logic [1:0] {WWD_OFF, WWD_ARMED, WWD_RUN} wwd_state_t;

  // Ticks per timebase step for each selector value.
  function automatic logic [MULT_W-1:0] wwd_tb_mult(input logic [2:0] sel);
    case (sel)
      3'h0: wwd_tb_mult = 14'h0001;
      3'h1: wwd_tb_mult = 14'h000A;
      3'h2: wwd_tb_mult = 14'h0032;
      3'h3: wwd_tb_mult = 14'h0064;
      3'h4: wwd_tb_mult = 14'h01F4;
      3'h5: wwd_tb_mult = 14'h03E8;
      3'h6: wwd_tb_mult = 14'h1388;
      default: wwd_tb_mult = 14'h2710;
    endcase
  endfunction : wwd_tb_mult
endpackage : wwd_pkg
`default_nettype wire

// ==== shared/wwd_tick_if.sv ====
// Tick timer handshake between the watchdog core and its prescaler.
`default_nettype none
interface wwd_tick_if;
  logic restart;
  logic tick;
  modport gen (input restart, output tick);
  modport user (output restart, input tick);
endinterface : wwd_tick_if
`default_nettype wire

// ==== verilog/wwd_tick_gen.sv ====
// Prescaler that turns the system clock into one-tick pulses.
`default_nettype none
module wwd_tick_gen
  import wwd_pkg::*;
#(
  parameter int TICK_CYC_P = TICK_CYC
) (
  input wire logic sys_clk, // System clock.
  input wire logic resetn, // Synchronous reset, active low.
  wwd_tick_if.gen tk // Restart in, tick pulse out.
);
  logic [TICK_CNT_W-1:0] cnt;
  wire logic at_end = (cnt == TICK_CNT_W'(TICK_CYC_P - 1));

  // A restart realigns the phase so that each window is measured
  // in whole ticks from the service itself.
  always_ff @(posedge sys_clk) begin
    if (!resetn || tk.restart || at_end) begin
      cnt <= '0;
    end else begin
      cnt <= cnt + TICK_CNT_W'(1);
    end
  end

  assign tk.tick = at_end && !tk.restart;
endmodule : wwd_tick_gen
`default_nettype wire

// ==== verilog/wwd_pin_kick.sv ====
// Synchroniser and edge detector for service events on the pin.
`default_nettype none
module wwd_pin_kick
  import wwd_pkg::*;
(
  input wire logic sys_clk, // System clock.
  input wire logic resetn, // Synchronous reset, active low.
  input wire logic pin_in, // Raw level of the general-purpose pin.
  input wire logic [1:0] kick_sel, // Service source selection.
  input wire logic pin_is_input, // Pin configured as an input.
  output logic pin_level, // Synchronised pin level.
  output logic pin_kick // One-cycle service pulse from the pin.
);
  logic meta;
  logic sync;
  logic prev;

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      meta <= 1'b1;
      sync <= 1'b1;
      prev <= 1'b1;
    end else begin
      meta <= pin_in;
      sync <= meta;
      prev <= sync;
    end
  end

  wire logic rise = sync && !prev;
  wire logic fall = !sync && prev;
  wire logic sel_fall = (kick_sel == SEL_PIN_FALL);
  wire logic sel_rise = (kick_sel == SEL_PIN_RISE) ||
                        (kick_sel == SEL_PIN_RISE_ALT);

  assign pin_level = sync;
  // Select 11 matches neither term, so the pin is ignored.
  assign pin_kick = pin_is_input &&
                    ((sel_fall && fall) || (sel_rise && rise));
endmodule : wwd_pin_kick
`default_nettype wire

// ==== verilog/wwd_top.sv ====
// Window watchdog core with its registers, pin path and fault outputs.
`default_nettype none
module wwd_top
  import wwd_pkg::*;
#(
  parameter int TICK_CYC_P = TICK_CYC
) (
  input wire logic sys_clk, // System clock, 125 MHz.
  input wire logic resetn, // Synchronous reset, active low.
  input wire logic [7:0] reg_addr, // Register address from the serial port.
  input wire logic [7:0] reg_wdata, // Register write data.
  input wire logic reg_wr, // Write strobe, one cycle.
  input wire logic reg_rd, // Read strobe, one cycle.
  output logic [7:0] reg_rdata, // Read data, valid the cycle after reg_rd.
  input wire logic gpio_in, // Level seen on the general-purpose pin.
  output logic gpio_out, // Pin output value, open drain so always low.
  output logic gpio_oe, // Pin output enable, high pulls the pin low.
  input wire logic [2:0] fault_clear, // Clear restart, slow, fast flags.
  output logic fault_too_fast, // Sticky too-fast fault flag.
  output logic fault_too_slow, // Sticky too-slow fault flag.
  output logic fault_restart, // Sticky restart fault flag.
  output logic shutdown_all, // Request to shut down every output.
  output logic shutdown_lv, // Request to shut down low-voltage outputs.
  output logic wd_running // Window timing is active.
);
  logic [7:0] cfg;
  logic [7:0] upper;
  logic [7:0] lower;
  logic [7:0] pin_cfg;
  wwd_state_t state;
  wwd_state_t next_state;
  logic [UNIT_W-1:0] elapsed;
  logic [UNIT_W-1:0] next_elapsed;
  logic pin_level;
  logic pin_kick;

  wwd_tick_if tk ();

  wwd_tick_gen #(
    .TICK_CYC_P(TICK_CYC_P)
  ) u_tick (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .tk(tk.gen)
  );

  wire logic pin_input_mode =
    (pin_cfg[PIN_MODE_MSB:PIN_MODE_LSB] == PIN_MODE_INPUT);

  wwd_pin_kick u_pin (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .pin_in(gpio_in),
    .kick_sel(cfg[CFG_SEL_MSB:CFG_SEL_LSB]),
    .pin_is_input(pin_input_mode),
    .pin_level(pin_level),
    .pin_kick(pin_kick)
  );

  // Register decode.
  wire logic hit_cfg = (reg_addr == ADDR_CFG);
  wire logic hit_upper = (reg_addr == ADDR_UPPER);
  wire logic hit_lower = (reg_addr == ADDR_LOWER);
  wire logic hit_service = (reg_addr == ADDR_SERVICE);
  wire logic hit_pin = (reg_addr == ADDR_PIN);

  // The lock only holds while the watchdog is enabled, so clearing the
  // enable bit beforehand is impossible once locked; only reset frees it.
  wire logic locked = cfg[CFG_LOCK] && cfg[CFG_EN];
  wire logic param_wr = reg_wr && !locked;
  wire logic cfg_wr = param_wr && hit_cfg;
  wire logic upper_wr = param_wr && hit_upper;
  wire logic lower_wr = param_wr && hit_lower;
  wire logic pin_wr = reg_wr && hit_pin;

  // Service events: the register path never depends on the selection.
  wire logic reg_kick = reg_wr && hit_service &&
                        (reg_wdata == SERVICE_VALUE);
  wire logic kick = reg_kick || pin_kick;

  // Window periods in ticks.
  wire logic [3:0] lo_cnt = lower[LIM_CNT_MSB:LIM_CNT_LSB];
  wire logic [2:0] lo_tb = lower[LIM_TB_MSB:LIM_TB_LSB];
  wire logic [3:0] hi_cnt = upper[LIM_CNT_MSB:LIM_CNT_LSB];
  wire logic [2:0] hi_tb = upper[LIM_TB_MSB:LIM_TB_LSB];
  wire logic [UNIT_W-1:0] lo_period =
    UNIT_W'(lo_cnt) * UNIT_W'(wwd_tb_mult(lo_tb));
  wire logic [UNIT_W-1:0] hi_period =
    UNIT_W'(hi_cnt) * UNIT_W'(wwd_tb_mult(hi_tb));
  wire logic [UNIT_W-1:0] restart_period = {hi_period[UNIT_W-2:0], 1'b0};

  wire logic detect_en = (upper != 8'h00) || (lower != 8'h00);
  wire logic running = (state == WWD_RUN);
  wire logic [UNIT_W-1:0] elapsed_inc = elapsed + UNIT_W'(1);
  wire logic slow_armed = detect_en && (hi_period != '0);
  wire logic counting = running && !kick && tk.tick &&
                        (elapsed < restart_period);

  // Fault events, each a one-cycle pulse.
  wire logic fast_evt = running && kick && detect_en &&
                        (elapsed < lo_period);
  wire logic slow_evt = counting && slow_armed &&
                        (elapsed_inc == hi_period);
  wire logic restart_evt = counting && slow_armed &&
                           (elapsed_inc == restart_period);

  // The prescaler is held in phase with each service and while idle.
  assign tk.restart = kick || !running;

  // Sequencing of enable and first service.
  always_comb begin
    next_state = state;
    case (state)
      WWD_OFF: begin
        if (cfg[CFG_EN]) begin
          next_state = WWD_ARMED;
        end
      end
      WWD_ARMED: begin
        if (!cfg[CFG_EN]) begin
          next_state = WWD_OFF;
        end else if (kick) begin
          next_state = WWD_RUN;
        end
      end
      WWD_RUN: begin
        if (!cfg[CFG_EN]) begin
          next_state = WWD_OFF;
        end
      end
      default: begin
        next_state = WWD_OFF;
      end
    endcase
  end

  // The counter saturates at the restart point so a dead host gives one
  // restart fault rather than a stream of them.
  always_comb begin
    next_elapsed = elapsed;
    if (!running || kick) begin
      next_elapsed = '0;
    end else if (counting) begin
      next_elapsed = elapsed_inc;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      state <= WWD_OFF;
      elapsed <= '0;
    end else begin
      state <= next_state;
      elapsed <= next_elapsed;
    end
  end

  // Registers; reset models the enable pin or a supply cycle.
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      cfg <= CFG_RST;
      upper <= LIMIT_RST;
      lower <= LIMIT_RST;
      pin_cfg <= PIN_RST;
    end else begin
      if (cfg_wr) begin
        cfg <= reg_wdata;
      end
      if (upper_wr) begin
        upper <= reg_wdata & LIM_MASK;
      end
      if (lower_wr) begin
        lower <= reg_wdata & LIM_MASK;
      end
      if (pin_wr) begin
        pin_cfg <= reg_wdata;
      end
    end
  end

  // Per-fault vectors, ordered as fault_clear: fast, slow, restart.
  wire logic [2:0] fault_evt = {restart_evt, slow_evt, fast_evt};
  wire logic [2:0] sd_en =
    {cfg[CFG_RESTART_SD], cfg[CFG_SLOW_SD], cfg[CFG_FAST_SD]};
  logic [2:0] flag;
  wire logic [2:0] next_flag;
  wire logic [2:0] sd_hit;

  // Sticky fault flags; a new event wins over a clear in the same cycle,
  // so a fault that lands on the host's clear is never lost.
  for (genvar i = 0; i < 3; i++) begin : g_fault
    assign next_flag[i] = fault_evt[i] ||
                          (flag[i] && !fault_clear[i]);
    assign sd_hit[i] = next_flag[i] && sd_en[i];
  end

  wire logic sd_req = |sd_hit;
  // Hiccup or latch-off timing lives in the fault manager downstream;
  // it lowers the request by clearing the flags.
  wire logic next_sd_all = sd_req && !cfg[CFG_SCOPE];
  wire logic next_sd_lv = sd_req && cfg[CFG_SCOPE];

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      flag <= 3'h0;
      shutdown_all <= 1'b0;
      shutdown_lv <= 1'b0;
      wd_running <= 1'b0;
    end else begin
      flag <= next_flag;
      shutdown_all <= next_sd_all;
      shutdown_lv <= next_sd_lv;
      wd_running <= (next_state == WWD_RUN);
    end
  end

  assign fault_too_fast = flag[0];
  assign fault_too_slow = flag[1];
  assign fault_restart = flag[2];

  // Pin driver: open drain, the enable pulls the pin low.
  wire logic any_fault = |flag;
  wire logic [2:0] pin_mode = pin_cfg[PIN_MODE_MSB:PIN_MODE_LSB];
  wire logic next_oe =
    (pin_mode == PIN_MODE_INIT) ||
    ((pin_mode == PIN_MODE_FAULT) && any_fault) ||
    ((pin_mode == PIN_MODE_LEVEL) && !pin_cfg[PIN_LEVEL_BIT]);

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      gpio_oe <= 1'b0;
    end else begin
      gpio_oe <= next_oe && !pin_input_mode;
    end
  end

  assign gpio_out = 1'b0;

  // Read path; the service register is write-only and reads zero.
  wire logic [7:0] pin_rd = {pin_level, pin_cfg[6:0]};
  wire logic [7:0] rd_mux =
    hit_cfg ? cfg :
    hit_upper ? upper :
    hit_lower ? lower :
    hit_pin ? pin_rd : 8'h00;

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata <= rd_mux;
    end
  end
endmodule : wwd_top
`default_nettype wire

// ==== test/wwd_host_pin.sv ====
// Host side of the open-drain service pin, with its board pull-up.
`default_nettype none
module wwd_host_pin (
  input wire logic gpio_oe, // Device pulls the pin low.
  input wire logic host_low, // Host pulls the pin low.
  output logic gpio_in // Resolved pin level.
);
  timeunit 1ns;
  timeprecision 1ps;
  // Either side may pull low; only the pull-up raises the line.
  assign gpio_in = !(gpio_oe || host_low);
endmodule : wwd_host_pin
`default_nettype wire

// ==== test/wwd_top_assertions.sv ====
// Port assertions for the window watchdog.
`default_nettype none
module wwd_top_assertions
  import wwd_pkg::*;
#(
  parameter int TICK_CYC_P = TICK_CYC
) (
  input wire logic sys_clk, // Clock.
  input wire logic resetn, // Reset.
  input wire logic [7:0] reg_addr, // Address.
  input wire logic [7:0] reg_wdata, // Write data.
  input wire logic reg_wr, // Write strobe.
  input wire logic reg_rd, // Read strobe.
  input wire logic [7:0] reg_rdata, // Read data.
  input wire logic gpio_in, // Pin level.
  input wire logic gpio_out, // Pin value.
  input wire logic gpio_oe, // Pin enable.
  input wire logic [2:0] fault_clear, // Flag clears.
  input wire logic fault_too_fast, // Fast flag.
  input wire logic fault_too_slow, // Slow flag.
  input wire logic fault_restart, // Restart flag.
  input wire logic shutdown_all, // Full shutdown.
  input wire logic shutdown_lv, // Partial shutdown.
  input wire logic wd_running // Timing active.
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!resetn);
  logic rd_svc;
  logic rd_lim;
  logic sd_any;
  logic flag_any;
  logic rd_pin;
  assign rd_svc = reg_rd && reg_addr == ADDR_SERVICE;
  assign rd_lim = reg_rd && (reg_addr == ADDR_UPPER || reg_addr == ADDR_LOWER);
  assign sd_any = shutdown_all || shutdown_lv;
  assign flag_any = fault_too_fast || fault_too_slow || fault_restart;
  assign rd_pin = reg_rd && reg_addr == ADDR_PIN;
  chk_pin_drain: assert property (gpio_out == 1'h0)
    else $error("pin output not low");
  chk_pin_release: assert property (rd_pin |=> !gpio_oe ||
    reg_rdata[2:0] != PIN_MODE_INPUT) else $error("pin driven in input mode");
  chk_service_rd: assert property (rd_svc |=> reg_rdata == 8'h00)
    else $error("service register read not zero");
  chk_limit_msb: assert property (rd_lim |=> !reg_rdata[7])
    else $error("limit bit 7 read as one");
  chk_scope_one: assert property (!(shutdown_all && shutdown_lv))
    else $error("both shutdown scopes requested");
  chk_sd_cause: assert property (sd_any
    |-> flag_any) else $error("shutdown without a fault flag");
  chk_fast_hold: assert property (fault_too_fast && !fault_clear[0]
    |=> fault_too_fast) else $error("fast flag dropped by itself");
  chk_slow_hold: assert property (fault_too_slow && !fault_clear[1]
    |=> fault_too_slow) else $error("slow flag dropped by itself");
  chk_restart_hold: assert property (fault_restart && !fault_clear[2]
    |=> fault_restart) else $error("restart flag dropped by itself");
  chk_fast_run: assert property ($rose(fault_too_fast)
    |-> $past(wd_running)) else $error("fast fault while not running");
  chk_slow_run: assert property ($rose(fault_too_slow)
    |-> $past(wd_running)) else $error("slow fault while not running");
  cov_fast: cover property ($rose(fault_too_fast));
  cov_restart: cover property ($rose(fault_restart));
  cov_partial: cover property (shutdown_lv);
endmodule : wwd_top_assertions
bind wwd_top wwd_top_assertions #(.TICK_CYC_P(TICK_CYC_P)) i_chk (
  .sys_clk, .resetn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
  .gpio_in, .gpio_out, .gpio_oe, .fault_clear, .fault_too_fast,
  .fault_too_slow, .fault_restart, .shutdown_all, .shutdown_lv, .wd_running
);
`default_nettype wire

// ==== test/wwd_top_test.sv ====
// Self-checking bench for the window watchdog.
`default_nettype none
module wwd_top_test
  import wwd_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;
  // A short tick keeps the timed windows to a few dozen clocks.
  localparam int TK = 4;
  logic sys_clk = 1'h0;
  logic resetn = 1'h0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'h0;
  logic reg_rd = 1'h0;
  logic [2:0] fault_clear = 3'h0;
  logic host_low = 1'h0;
  logic [7:0] reg_rdata;
  logic gpio_in, gpio_out, gpio_oe;
  logic fault_too_fast, fault_too_slow, fault_restart;
  logic shutdown_all, shutdown_lv, wd_running;
  int error_cnt = 0;
  int comparisons = 0;
  always #4 sys_clk = ~sys_clk;
  wwd_top #(.TICK_CYC_P(TK)) i_dut (
    .sys_clk, .resetn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .gpio_in, .gpio_out, .gpio_oe, .fault_clear, .fault_too_fast,
    .fault_too_slow, .fault_restart, .shutdown_all, .shutdown_lv, .wd_running
  );
  wwd_host_pin i_host (.gpio_oe, .host_low, .gpio_in);
  task automatic chk(input string w, input logic [7:0] e, input logic [7:0] g);
    comparisons++;
    if (g !== e) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", w, e, g);
    end
  endtask : chk
  task automatic wt(input int n);
    repeat (n) @(negedge sys_clk);
  endtask : wt
  // Each access ends one idle cycle later so strobes never toggle twice.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'h1;
    wt(1);
    reg_wr = 1'h0;
    wt(1);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] e, input string w);
    reg_addr = a;
    reg_rd = 1'h1;
    wt(1);
    reg_rd = 1'h0;
    chk(w, e, reg_rdata);
    wt(1);
  endtask : rd
  task automatic flags(input logic [2:0] e, input string w);
    chk(w, {5'h00, e}, {5'h00, fault_restart, fault_too_slow, fault_too_fast});
  endtask : flags
  task automatic clear_all;
    fault_clear = 3'h7;
    wt(1);
    fault_clear = 3'h0;
  endtask : clear_all
  task automatic do_reset;
    resetn = 1'h0;
    wt(5);
    resetn = 1'h1;
    wt(1);
  endtask : do_reset
  task automatic fast_case(input logic [7:0] cfg, input logic lv);
    wr(ADDR_CFG, 8'h00);
    clear_all;
    wr(ADDR_CFG, cfg);
    wr(ADDR_SERVICE, SERVICE_VALUE);
    wr(ADDR_SERVICE, SERVICE_VALUE);
    wt(3);
    flags(3'h1, "fast flag");
    chk("partial shutdown", {7'h00, lv}, {7'h00, shutdown_lv});
    chk("full shutdown", 8'h00, {7'h00, shutdown_all});
  endtask : fast_case
  task automatic pin_case(input logic [1:0] sel);
    wr(ADDR_CFG, {6'h20, sel});
    wr(ADDR_SERVICE, SERVICE_VALUE);
    host_low = 1'h1;
    wt(6);
    flags({2'h0, sel == SEL_PIN_FALL}, "pin fall");
    host_low = 1'h0;
    wt(6);
    flags({2'h0, sel != SEL_REG_ONLY}, "pin rise");
    wr(ADDR_CFG, 8'h00);
    clear_all;
  endtask : pin_case
  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : finish_test
  initial begin
    repeat (3000) @(posedge sys_clk);
    error_cnt++;
    finish_test;
  end
  initial begin
    do_reset;
    rd(ADDR_CFG, CFG_RST, "config");
    rd(ADDR_UPPER, LIMIT_RST, "upper");
    rd(ADDR_LOWER, LIMIT_RST, "lower");
    wr(ADDR_UPPER, 8'h93);
    rd(ADDR_UPPER, 8'h13, "upper");
    wr(ADDR_LOWER, 8'hFF);
    rd(ADDR_LOWER, 8'h7F, "lower");
    rd(ADDR_SERVICE, 8'h00, "service");
    rd(8'h10, 8'h00, "unmapped");
    wr(ADDR_UPPER, 8'h00);
    wr(ADDR_LOWER, 8'h00);
    $display("test registers done");
    wr(ADDR_CFG, 8'hF3);
    wr(ADDR_SERVICE, SERVICE_VALUE);
    wr(ADDR_SERVICE, SERVICE_VALUE);
    wt(20);
    flags(3'h0, "no limits");
    $display("test zero limits done");
    wr(ADDR_CFG, 8'h73);
    wr(ADDR_UPPER, 8'h04);
    wr(ADDR_LOWER, 8'h01);
    wr(ADDR_CFG, 8'hF3);
    chk("armed", 8'h00, {7'h00, wd_running});
    wr(ADDR_SERVICE, SERVICE_VALUE);
    chk("running", 8'h01, {7'h00, wd_running});
    wt(8);
    wr(ADDR_SERVICE, SERVICE_VALUE);
    flags(3'h0, "in window");
    wt(8);
    flags(3'h0, "before slow");
    wt(13);
    flags(3'h2, "slow");
    chk("full shutdown", 8'h01, {7'h00, shutdown_all});
    wt(20);
    flags(3'h6, "restart");
    $display("test window done");
    fast_case(8'hEB, 1'h0);
    fast_case(8'hDB, 1'h1);
    $display("test shutdown done");
    wr(ADDR_CFG, 8'hF7);
    wr(ADDR_UPPER, 8'h05);
    rd(ADDR_UPPER, 8'h04, "locked upper");
    wr(ADDR_CFG, 8'h00);
    rd(ADDR_CFG, 8'hF7, "locked config");
    do_reset;
    rd(ADDR_CFG, CFG_RST, "config");
    $display("test lock done");
    chk("pin drive", 8'h01, {7'h00, gpio_oe});
    chk("pin value", 8'h00, {7'h00, gpio_out});
    wr(ADDR_PIN, 8'h04);
    wt(3);
    chk("pin enable", 8'h00, {7'h00, gpio_oe});
    rd(ADDR_PIN, 8'h84, "pin input");
    wr(ADDR_LOWER, 8'h0F);
    for (int s = 0; s < 4; s++) begin
      pin_case(2'(s));
    end
    $display("test pin service done");
    wr(ADDR_PIN, 8'h06);
    chk("level low", 8'h01, {7'h00, gpio_oe});
    wr(ADDR_PIN, 8'h16);
    chk("level high", 8'h00, {7'h00, gpio_oe});
    wr(ADDR_PIN, 8'h01);
    chk("fault pin idle", 8'h00, {7'h00, gpio_oe});
    wr(ADDR_CFG, 8'h83);
    wr(ADDR_SERVICE, SERVICE_VALUE);
    wr(ADDR_SERVICE, SERVICE_VALUE);
    flags(3'h1, "pin fault");
    chk("fault pin", 8'h01, {7'h00, gpio_oe});
    $display("test pin modes done");
    finish_test;
  end
endmodule : wwd_top_test
`default_nettype wire
